//--- pct_map.svh
// Register offsets, field positions and reset values of the control timer
`ifndef PCT_MAP_SVH
`define PCT_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define PCT_CTRL   8'h00
`define PCT_CHMODE 8'h04
`define PCT_DTIME  8'h08
`define PCT_PSC    8'h0c
`define PCT_ARR    8'h10
`define PCT_CNT    8'h14
`define PCT_STAT   8'h18
`define PCT_MASK   8'h1c
`define PCT_DMAEN  8'h20
`define PCT_CCR0   8'h40
`define PCT_CCR_END 8'h50

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define PCT_CTRL_EN   0
`define PCT_CTRL_DIR  1
`define PCT_CTRL_CMS  2
`define PCT_CTRL_OPM  4
`define PCT_CTRL_FRZ  5
`define PCT_CTRL_TRG  6
`define PCT_CTRL_MOE  8
`define PCT_CTRL_W    9

// ----------------------------------------------------------------------
// Status layout, sizes and reset values
// ----------------------------------------------------------------------
`define PCT_STAT_UIF  0
`define PCT_STAT_W    5
`define PCT_MAX_CH    4
`define PCT_ARR_RST   16'hffff
`define PCT_ZERO16    16'h0000

`endif

//--- pct_pkg.sv
// Types shared by the control timer modules
package pct_pkg;
  // Counting modes held in the control register
  typedef enum logic [1:0] {CM_EDGE, CM_CENTER, CM_ENCODER, CM_SPARE} pct_cmode_t;
  // What a trigger input rising edge does
  typedef enum logic [1:0] {TM_NONE, TM_START, TM_EXTCLK, TM_RESET} pct_tmode_t;
  // Per-channel function
  typedef enum logic [1:0] {CH_OFF, CH_CAPTURE, CH_TOGGLE, CH_PWM} pct_chmode_t;
endpackage : pct_pkg

//--- pct_channel.sv
// One capture/compare channel of the control timer
`timescale 1ns/1ps
module pct_channel (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  input  wire logic [1:0]  mode,
  input  wire logic [15:0] cnt,
  input  wire logic [15:0] ccr,
  input  wire logic        fresh,
  input  wire logic        cap_in,
  output logic             ref_o,
  output logic             cap_evt,
  output logic             cmp_evt
);
  logic cap_q_r;
  logic ref_r;
  pct_pkg::pct_chmode_t md;

  assign md      = pct_pkg::pct_chmode_t'(mode);
  assign ref_o   = ref_r;
  // Rising edge on the capture pin while in capture mode
  assign cap_evt = (md == pct_pkg::CH_CAPTURE) & cap_in & ~cap_q_r;
  // Match only on a counter value that is new this cycle
  assign cmp_evt = fresh & (cnt == ccr) & (md != pct_pkg::CH_OFF)
                   & (md != pct_pkg::CH_CAPTURE);

  // Edge detector for the capture pin
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cap_q_r <= 1'b0;
    end else if (clk_en) begin
      cap_q_r <= cap_in;
    end
  end

  // Reference waveform; cnt < ccr gives 0% at ccr=0 and 100% above reload
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ref_r <= 1'b0;
    end else if (clk_en) begin
      case (md)
        pct_pkg::CH_PWM:    ref_r <= (cnt < ccr);
        pct_pkg::CH_TOGGLE: ref_r <= cmp_evt ? ~ref_r : ref_r;
        default:            ref_r <= 1'b0;
      endcase
    end
  end
endmodule : pct_channel

//--- pct_deadtime.sv
// Dead-time generator for one complementary output pair
`timescale 1ns/1ps
module pct_deadtime #(
  parameter int DTW = 8
) (
  input  wire logic           clock,
  input  wire logic           resetn,
  input  wire logic           clk_en,
  input  wire logic           ref_i,
  input  wire logic           oe,
  input  wire logic [DTW-1:0] dtime,
  output logic                out_p,
  output logic                out_n
);
  logic           ref_q_r;
  logic [DTW-1:0] dt_cnt_r;
  logic           quiet;

  // Both sides stay low until the dead time since the last edge has run out
  assign quiet = (dt_cnt_r == '0) & (ref_i == ref_q_r);

  // Restart the dead-time count on every reference edge
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ref_q_r  <= 1'b0;
      dt_cnt_r <= '0;
    end else if (clk_en) begin
      ref_q_r <= ref_i;
      if (ref_i != ref_q_r) begin
        dt_cnt_r <= dtime;
      end else if (dt_cnt_r != '0) begin
        dt_cnt_r <= dt_cnt_r - 1'b1;
      end
    end
  end

  // Registered pair, never high together
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      out_p <= 1'b0;
      out_n <= 1'b0;
    end else if (clk_en) begin
      out_p <= oe & quiet & ref_q_r;
      out_n <= oe & quiet & ~ref_q_r;
    end
  end
endmodule : pct_deadtime

//--- pct_timer.sv
// Control timer top: APB registers, prescaler, counter, channels, outputs
`timescale 1ns/1ps
`include "pct_map.svh"
module pct_timer #(
  parameter int NUM_CH    = 4,    // Channels, 1 to 4
  parameter int NUM_CMP   = 3,    // Complementary pairs, 1 to NUM_CH
  parameter bit UPDOWN_EN = 1'b1, // Zero builds an up-only counter
  parameter bit DMA_EN    = 1'b1  // Zero removes DMA requests
) (
  input  wire logic               clock,
  input  wire logic               resetn,
  input  wire logic               clk_en,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               dbg_halt,
  input  wire logic               trig_in,
  output logic                    trig_out,
  input  wire logic               enc_a,
  input  wire logic               enc_b,
  input  wire logic [NUM_CH-1:0]  cap_in,
  output logic      [NUM_CH-1:0]  ch_out,
  output logic      [NUM_CMP-1:0] chn_out,
  output logic                    dma_req,
  output logic                    irq
);
  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [`PCT_CTRL_W-1:0] ctrl_r;
  logic [7:0]             chmode_r;
  logic [7:0]             dtime_r;
  logic [15:0]            psc_r;
  logic [15:0]            psc_cnt_r;
  logic [15:0]            arr_r;
  logic [15:0]            cnt_r;
  logic [15:0]            cnt_nxt;
  logic                   cdir_r;
  logic                   cdir_nxt;
  logic                   fresh_r;
  logic [`PCT_STAT_W-1:0] sts_r;
  logic [`PCT_STAT_W-1:0] mask_r;
  logic [`PCT_STAT_W-1:0] dmaen_r;
  logic [`PCT_STAT_W-1:0] sts_set;
  logic [15:0]            ccr_r [`PCT_MAX_CH];
  logic                   trig_q_r;
  logic                   enc_a_q_r;
  logic [31:0]            prdata_r;
  logic                   pready_r;
  logic                   pslverr_r;
  logic                   trig_out_r;
  logic                   dma_r;
  logic                   irq_r;
  logic [31:0]            rd_data;
  logic                   rd_ok;
  logic                   acc;
  logic                   wr_go;
  logic                   halted;
  logic                   oe;
  logic                   trig_rise;
  logic                   src_tick;
  logic                   psc_tick;
  logic                   step;
  logic                   going_down;
  logic                   upd;
  logic [`PCT_MAX_CH-1:0] cap_evt;
  logic [`PCT_MAX_CH-1:0] cmp_evt;
  logic [`PCT_MAX_CH-1:0] ref_w;
  logic [`PCT_MAX_CH-1:0] pos_w;
  logic [`PCT_MAX_CH-1:0] neg_w;
  pct_pkg::pct_cmode_t    cmode;
  pct_pkg::pct_tmode_t    tmode;

  // ----------------------------------------------------------------------
  // Address decode helpers
  // ----------------------------------------------------------------------
  // Channel compare register window, aligned words only so odd writes are refused
  function automatic logic is_ccr(input logic [7:0] a);
    is_ccr = (a >= `PCT_CCR0) && (a < `PCT_CCR_END) && (a[1:0] == 2'b00);
  endfunction : is_ccr

  // Channel number inside that window
  function automatic logic [1:0] ccr_idx(input logic [7:0] a);
    ccr_idx = a[3:2];
  endfunction : ccr_idx

  // ----------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------
  // Up-only builds ignore the direction and center bits
  assign cmode  = UPDOWN_EN ? pct_pkg::pct_cmode_t'(ctrl_r[`PCT_CTRL_CMS +: 2])
                            : pct_pkg::CM_EDGE;
  assign tmode  = pct_pkg::pct_tmode_t'(ctrl_r[`PCT_CTRL_TRG +: 2]);
  assign halted = dbg_halt & ctrl_r[`PCT_CTRL_FRZ];
  assign oe     = ctrl_r[`PCT_CTRL_MOE] & ~halted;
  assign trig_rise = trig_in & ~trig_q_r;
  assign acc    = psel & penable;
  assign wr_go  = acc & pwrite & pready_r;

  // ----------------------------------------------------------------------
  // Prescaler and count step
  // ----------------------------------------------------------------------
  // External clock mode counts trigger edges instead of clock cycles
  assign src_tick = (tmode == pct_pkg::TM_EXTCLK) ? trig_rise : 1'b1;
  // Division by psc+1, so 1 to 65536
  // A count left above a newly written smaller divider ends at once, not after a wrap
  assign psc_tick = src_tick & (psc_cnt_r >= psc_r);

  // Encoder mode steps on each phase A edge and bypasses the prescaler
  always_comb begin
    if (cmode == pct_pkg::CM_ENCODER) begin
      step       = ctrl_r[`PCT_CTRL_EN] & ~halted & (enc_a != enc_a_q_r);
      going_down = (enc_a == enc_b);
    end else begin
      step       = ctrl_r[`PCT_CTRL_EN] & ~halted & psc_tick;
      going_down = (cmode == pct_pkg::CM_CENTER) ? cdir_r : (UPDOWN_EN & ctrl_r[`PCT_CTRL_DIR]);
    end
  end

  // Prescaler counter; held while the timer is stopped or frozen
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      psc_cnt_r <= `PCT_ZERO16;
    end else if (clk_en) begin
      if (!ctrl_r[`PCT_CTRL_EN] || halted) begin
        psc_cnt_r <= psc_cnt_r;
      end else if (psc_tick) begin
        psc_cnt_r <= `PCT_ZERO16;
      end else if (src_tick) begin
        psc_cnt_r <= psc_cnt_r + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Counter next value and update event
  // ----------------------------------------------------------------------
  // Center mode turns round at the ends, edge mode wraps and reloads
  always_comb begin
    cnt_nxt  = cnt_r;
    cdir_nxt = cdir_r;
    upd      = 1'b0;
    if (step) begin
      if (going_down) begin
        if (cnt_r == `PCT_ZERO16) begin
          upd = 1'b1;
          if (cmode == pct_pkg::CM_CENTER) begin
            cdir_nxt = 1'b0;
            cnt_nxt  = 16'h0001;
          end else begin
            cnt_nxt = arr_r;
          end
        end else begin
          cnt_nxt = cnt_r - 16'h0001;
        end
      end else begin
        if (cnt_r >= arr_r) begin
          upd = 1'b1;
          if (cmode == pct_pkg::CM_CENTER) begin
            cdir_nxt = 1'b1;
            cnt_nxt  = arr_r - 16'h0001;
          end else begin
            cnt_nxt = `PCT_ZERO16;
          end
        end else begin
          cnt_nxt = cnt_r + 16'h0001;
        end
      end
    end
  end

  // Counter register; a software write or a reset trigger takes priority
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_r   <= `PCT_ZERO16;
      cdir_r  <= 1'b0;
      fresh_r <= 1'b0;
    end else if (clk_en) begin
      fresh_r <= step;
      if (wr_go && paddr == `PCT_CNT) begin
        cnt_r <= pwdata[15:0];
      end else if (tmode == pct_pkg::TM_RESET && trig_rise) begin
        cnt_r  <= `PCT_ZERO16;
        cdir_r <= 1'b0;
      end else begin
        cnt_r  <= cnt_nxt;
        cdir_r <= cdir_nxt;
      end
    end
  end

  // Input edge detectors for trigger and encoder phase A
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      trig_q_r  <= 1'b0;
      enc_a_q_r <= 1'b0;
    end else if (clk_en) begin
      trig_q_r  <= trig_in;
      enc_a_q_r <= enc_a;
    end
  end

  // ----------------------------------------------------------------------
  // Channels and output stages
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < `PCT_MAX_CH; i++) begin : g_ch
    if (i < NUM_CH) begin : g_on
      pct_channel u_ch (
        .clock   (clock),
        .resetn  (resetn),
        .clk_en  (clk_en),
        .mode    (chmode_r[2*i +: 2]),
        .cnt     (cnt_r),
        .ccr     (ccr_r[i]),
        .fresh   (fresh_r),
        .cap_in  (cap_in[i]),
        .ref_o   (ref_w[i]),
        .cap_evt (cap_evt[i]),
        .cmp_evt (cmp_evt[i])
      );
      if (i < NUM_CMP) begin : g_cmp
        pct_deadtime #(.DTW(8)) u_dt (
          .clock  (clock),
          .resetn (resetn),
          .clk_en (clk_en),
          .ref_i  (ref_w[i]),
          .oe     (oe),
          .dtime  (dtime_r),
          .out_p  (pos_w[i]),
          .out_n  (neg_w[i])
        );
      end else begin : g_single
        logic plain_r;
        // Outputs without a complement are gated the same way
        always_ff @(posedge clock or negedge resetn) begin
          if (!resetn) begin
            plain_r <= 1'b0;
          end else if (clk_en) begin
            plain_r <= oe & ref_w[i];
          end
        end
        assign pos_w[i] = plain_r;
        assign neg_w[i] = 1'b0;
      end
    end else begin : g_off
      assign ref_w[i]   = 1'b0;
      assign cap_evt[i] = 1'b0;
      assign cmp_evt[i] = 1'b0;
      assign pos_w[i]   = 1'b0;
      assign neg_w[i]   = 1'b0;
    end
  end

  assign ch_out  = pos_w[NUM_CH-1:0];
  assign chn_out = neg_w[NUM_CMP-1:0];

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  // Start trigger and one-pulse stop both act on the enable bit
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl_r   <= '0;
      chmode_r <= 8'h00;
      dtime_r  <= 8'h00;
      psc_r    <= `PCT_ZERO16;
      arr_r    <= `PCT_ARR_RST;
      mask_r   <= '0;
      dmaen_r  <= '0;
    end else if (clk_en) begin
      if (wr_go && paddr == `PCT_CTRL) begin
        ctrl_r <= pwdata[`PCT_CTRL_W-1:0];
      end else if (upd && ctrl_r[`PCT_CTRL_OPM]) begin
        ctrl_r[`PCT_CTRL_EN] <= 1'b0;
      end else if (tmode == pct_pkg::TM_START && trig_rise) begin
        ctrl_r[`PCT_CTRL_EN] <= 1'b1;
      end
      if (wr_go && paddr == `PCT_CHMODE) begin
        chmode_r <= pwdata[7:0];
      end
      if (wr_go && paddr == `PCT_DTIME) begin
        dtime_r <= pwdata[7:0];
      end
      if (wr_go && paddr == `PCT_PSC) begin
        psc_r <= pwdata[15:0];
      end
      if (wr_go && paddr == `PCT_ARR) begin
        arr_r <= pwdata[15:0];
      end
      if (wr_go && paddr == `PCT_MASK) begin
        mask_r <= pwdata[`PCT_STAT_W-1:0];
      end
      if (wr_go && paddr == `PCT_DMAEN) begin
        dmaen_r <= pwdata[`PCT_STAT_W-1:0];
      end
    end
  end

  // Compare registers; a capture in the write cycle wins
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int k = 0; k < `PCT_MAX_CH; k++) begin
        ccr_r[k] <= `PCT_ZERO16;
      end
    end else if (clk_en) begin
      for (int k = 0; k < `PCT_MAX_CH; k++) begin
        if (cap_evt[k]) begin
          ccr_r[k] <= cnt_r;
        end else if (wr_go && is_ccr(paddr) && ccr_idx(paddr) == 2'(k)) begin
          ccr_r[k] <= pwdata[15:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Events: status, interrupt, DMA, trigger out
  // ----------------------------------------------------------------------
  assign sts_set = {cap_evt | cmp_evt, upd};

  // Write one to clear; a new event in the same cycle stays set
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sts_r <= '0;
    end else if (clk_en) begin
      if (wr_go && paddr == `PCT_STAT) begin
        sts_r <= (sts_r & ~pwdata[`PCT_STAT_W-1:0]) | sts_set;
      end else begin
        sts_r <= sts_r | sts_set;
      end
    end
  end

  // Registered event outputs; the trigger pulse chains other timers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq_r      <= 1'b0;
      dma_r      <= 1'b0;
      trig_out_r <= 1'b0;
    end else if (clk_en) begin
      irq_r      <= |(sts_r & mask_r);
      dma_r      <= DMA_EN & (|(sts_set & dmaen_r));
      trig_out_r <= upd;
    end
  end

  assign irq      = irq_r;
  assign dma_req  = dma_r;
  assign trig_out = trig_out_r;

  // ----------------------------------------------------------------------
  // APB read and answer
  // ----------------------------------------------------------------------
  // Read multiplexer; unmapped addresses flag an error
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (paddr == `PCT_CTRL) begin
      rd_data[`PCT_CTRL_W-1:0] = ctrl_r;
    end else if (paddr == `PCT_CHMODE) begin
      rd_data[7:0] = chmode_r;
    end else if (paddr == `PCT_DTIME) begin
      rd_data[7:0] = dtime_r;
    end else if (paddr == `PCT_PSC) begin
      rd_data[15:0] = psc_r;
    end else if (paddr == `PCT_ARR) begin
      rd_data[15:0] = arr_r;
    end else if (paddr == `PCT_CNT) begin
      rd_data[15:0] = cnt_r;
    end else if (paddr == `PCT_STAT) begin
      rd_data[`PCT_STAT_W-1:0] = sts_r;
    end else if (paddr == `PCT_MASK) begin
      rd_data[`PCT_STAT_W-1:0] = mask_r;
    end else if (paddr == `PCT_DMAEN) begin
      rd_data[`PCT_STAT_W-1:0] = dmaen_r;
    end else if (is_ccr(paddr) && paddr[1:0] == 2'b00) begin
      rd_data[15:0] = ccr_r[ccr_idx(paddr)];
    end else begin
      rd_ok = 1'b0;
    end
  end

  // One wait state: data is registered in the first access cycle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready_r  <= acc & ~pready_r;
      pslverr_r <= acc & ~pready_r & ~rd_ok;
      if (acc && !pready_r && !pwrite) begin
        prdata_r <= rd_data;
      end
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
endmodule : pct_timer

//--- pct_timer_props.sv
// Concurrent checks on the control timer ports
`timescale 1ns/1ps
`include "pct_map.svh"
module pct_timer_props #(
  parameter int NUM_CH  = 4,
  parameter int NUM_CMP = 3
) (
  input wire logic               clock,
  input wire logic               resetn,
  input wire logic               clk_en,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [7:0]         paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic               dbg_halt,
  input wire logic               trig_out,
  input wire logic [NUM_CH-1:0]  ch_out,
  input wire logic [NUM_CMP-1:0] chn_out,
  input wire logic               dma_req,
  input wire logic               irq
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!resetn);
  logic frz_r;
  // Mirror of the freeze bit, so the halt check knows when it applies
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) frz_r <= 1'b0;
    else if (clk_en && psel && penable && pready && pwrite && paddr == `PCT_CTRL)
      frz_r <= pwdata[`PCT_CTRL_FRZ];
  end
  sequence s_setup; psel && !penable && clk_en; endsequence
  sequence s_access; psel && penable && clk_en; endsequence
  chk_ready_wait: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
    else $error("ready not after one wait state");
  chk_ready_pulse: assert property (pready && clk_en |=> !pready)
    else $error("ready longer than one cycle");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_err_data: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read data not zero");
  chk_reset_quiet: assert property ($rose(resetn) |-> !irq && !dma_req && !trig_out
    && ch_out == '0 && chn_out == '0) else $error("outputs active after reset");
  chk_freeze_off: assert property (dbg_halt && frz_r && clk_en |=> ch_out == '0
    && chn_out == '0) else $error("outputs on during debug freeze");
  chk_trig_pulse: assert property (trig_out && clk_en |=> !trig_out)
    else $error("trigger out not a pulse");
  chk_dma_pulse: assert property (dma_req && clk_en |=> !dma_req)
    else $error("dma request not a pulse");
endmodule : pct_timer_props

bind pct_timer pct_timer_props #(.NUM_CH(NUM_CH), .NUM_CMP(NUM_CMP)) i_pct_timer_props (
  .clock(clock), .resetn(resetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .dbg_halt(dbg_halt), .trig_out(trig_out), .ch_out(ch_out),
  .chn_out(chn_out), .dma_req(dma_req), .irq(irq));

//--- pct_enc_model.sv
// Quadrature encoder standing in for the shaft sensor
`timescale 1ns/1ps
module pct_enc_model (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic step,
  input  wire logic dir,
  output logic      enc_a,
  output logic      enc_b
);
  logic [1:0] phase_r;
  // Gray walk: one phase line moves per step, as on a real shaft
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) phase_r <= 2'h0;
    else if (step) phase_r <= dir ? phase_r - 2'h1 : phase_r + 2'h1;
  end
  // Phase a moves twice per turn, so a turn is worth two counts
  assign enc_a = phase_r[0] ^ phase_r[1];
  assign enc_b = phase_r[1];
endmodule : pct_enc_model

//--- tb.sv
// Self-checking bench of the control timer
`timescale 1ns/1ps
`include "pct_map.svh"
module tb;
  logic        clock, resetn, clk_en, psel, penable, pwrite, pready, pslverr, e;
  logic        dbg_halt, trig_in, trig_out, enc_a, enc_b, dma_req, irq, step, dir;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  cap_in, ch_out;
  logic [2:0]  chn_out;
  logic [15:0] ps, ar, v;
  int          n_fail, n_checks, k, h, g, gn;
  int          ccr [4] = '{0, 20, 4, 7};
  pct_timer i_pct_timer (.clock(clock), .resetn(resetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dbg_halt(dbg_halt), .trig_in(trig_in),
    .trig_out(trig_out), .enc_a(enc_a), .enc_b(enc_b), .cap_in(cap_in), .ch_out(ch_out),
    .chn_out(chn_out), .dma_req(dma_req), .irq(irq));
  pct_enc_model i_pct_enc_model (.clock(clock), .resetn(resetn), .step(step), .dir(dir),
    .enc_a(enc_a), .enc_b(enc_b));
  // 250 MHz clock
  always #2 clock = ~clock;
  // Bus cycle; releases at the ready edge, then idles one cycle so the next setup never lands on this edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
    if (k >= 20) begin
      n_fail++;
      $display("unexpected at %0t: no ready", $time);
    end
  endtask : apb
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, g, x);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc
  // Update spacing: center mode turns at both ends, so one count shorter
  function automatic int period(input bit c, input int p, input int a);
    return c ? (p + 1) * a : (p + 1) * (a + 1);
  endfunction : period
  // Cycles between two trigger pulses, bounded
  task automatic meas(output int c);
    k = 0;
    while (trig_out !== 1'b1 && k < 900) begin
      @(posedge clock);
      k++;
    end
    c = 0;
    do begin
      @(posedge clock);
      c++;
    end while (trig_out !== 1'b1 && c < 900);
  endtask : meas
  task automatic enc(input int n, input logic d);
    repeat (n) begin
      step <= 1'b1;
      dir <= d;
      @(posedge clock);
      step <= 1'b0;
      cyc(3);
    end
  endtask : enc
  task automatic tally_and_finish;
    if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  // Watchdog cuts a hung run short
  initial begin
    #40000;
    n_fail++;
    tally_and_finish();
  end
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(1));
    {clock, resetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {dbg_halt, trig_in, cap_in, step, dir} = '0;
    clk_en = 1'b1;
    cyc(20);
    resetn <= 1'b1;
    @(posedge clock);
    apb(0, `PCT_ARR, 0);
    chk(q, 32'h0000ffff);
    apb(0, 8'h24, 0);
    chk({e, q[30:0]}, 32'h80000000);
    apb(1, `PCT_DMAEN, 1);
    for (int m = 0; m < 3; m++) begin
      ps = (m == 0) ? 16'h0 : 16'($urandom % 4);
      ar = 16'(2 + $urandom % 8);
      apb(1, `PCT_PSC, {16'h0, ps});
      apb(1, `PCT_ARR, {16'h0, ar});
      apb(1, `PCT_CNT, 0);
      apb(1, `PCT_CTRL, (m == 1) ? 32'h5 : (m == 2) ? 32'h3 : 32'h1);
      meas(h);
      chk(h, period(m == 1, ps, ar));
      apb(1, `PCT_CTRL, 0);
    end
    apb(1, `PCT_PSC, 0);
    apb(1, `PCT_ARR, 9);
    apb(1, `PCT_CNT, 0);
    apb(1, `PCT_DTIME, 2);
    for (int i = 0; i < 4; i++) apb(1, 8'(`PCT_CCR0 + 4 * i), ccr[i]);
    apb(1, `PCT_CHMODE, 32'hff);
    apb(1, `PCT_MASK, 1);
    apb(1, `PCT_CTRL, 32'h121);
    cyc(30);
    h = 0;
    g = 0;
    gn = 0;
    repeat (40) begin
      @(posedge clock);
      h += ch_out[3];
      g += ch_out[2];
      gn += chn_out[2];
      chk({ch_out[1:0], chn_out[1:0]}, 4'b1001);
      chk(ch_out[2:0] & chn_out, 0);
    end
    chk(h, 28);
    // Each side loses the dead time of 2 plus one register stage per period of 10
    chk(g, 4 * (ccr[2] - 2 - 1));
    chk(gn, 4 * (10 - ccr[2] - 2 - 1));
    chk(irq, 1);
    dbg_halt <= 1'b1;
    cyc(3);
    chk({ch_out, chn_out}, 0);
    apb(0, `PCT_CNT, 0);
    v = q[15:0];
    cyc(5);
    apb(0, `PCT_CNT, 0);
    chk(q, {16'h0, v});
    dbg_halt <= 1'b0;
    apb(1, `PCT_CTRL, 0);
    apb(1, `PCT_STAT, 32'h1f);
    cyc(2);
    chk(irq, 0);
    apb(0, `PCT_STAT, 0);
    chk(q, 0);
    apb(1, `PCT_MASK, 0);
    apb(1, `PCT_CHMODE, 32'h40);
    v = 16'($urandom);
    apb(1, `PCT_CNT, {16'h0, v});
    cap_in <= 4'h8;
    cyc(3);
    cap_in <= 4'h0;
    apb(0, 8'h4c, 0);
    chk(q, {16'h0, v});
    apb(0, `PCT_STAT, 0);
    chk({irq, q[30:0]}, 32'h10);
    // Full range, so the encoder counts never meet the reload value
    apb(1, `PCT_ARR, 32'hffff);
    apb(1, `PCT_CTRL, 32'h9);
    apb(1, `PCT_CNT, 100);
    enc(8, 1'b0);
    apb(0, `PCT_CNT, 0);
    chk(q, 104);
    enc(12, 1'b1);
    apb(0, `PCT_CNT, 0);
    chk(q, 98);
    apb(1, `PCT_CTRL, 0);
    apb(1, `PCT_ARR, 5);
    apb(1, `PCT_CNT, 0);
    apb(1, `PCT_CTRL, 32'h50);
    trig_in <= 1'b1;
    cyc(2);
    trig_in <= 1'b0;
    h = 0;
    repeat (30) begin
      @(posedge clock);
      h += trig_out;
    end
    chk(h, 1);
    apb(0, `PCT_CTRL, 0);
    chk(q, 32'h50);
    // Toggle on match: a six-cycle count period gives a square wave of twelve
    apb(1, 8'h4c, 3);
    apb(1, `PCT_CHMODE, 32'h80);
    apb(1, `PCT_CTRL, 32'h101);
    cyc(20);
    h = 0;
    repeat (48) begin
      @(posedge clock);
      h += ch_out[3];
    end
    chk(h, 24);
    tally_and_finish();
  end
endmodule : tb
